// ---- common/nvm_pkg.sv ----
/*
  constants shared by the data-store device end and the cpu-side end:
  i/o register indices, control bit positions, mode codes, timing counts
  and the host's wishbone register map.
  assumes a single 250 MHz clock.
*/
package nvm_pkg;
  // data store geometry
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int REG_IDX_W = 2;
  // i/o register indices
  localparam logic [REG_IDX_W-1:0] REG_CTRL = 2'h0;
  localparam logic [REG_IDX_W-1:0] REG_DATA = 2'h1;
  localparam logic [REG_IDX_W-1:0] REG_ADDR_LO = 2'h2;
  localparam logic [REG_IDX_W-1:0] REG_ADDR_HI = 2'h3;
  // control register bits
  localparam int READ_BIT = 0;
  localparam int PE_BIT = 1;
  localparam int MPE_BIT = 2;
  localparam int RIE_BIT = 3;
  localparam int PM_LO_BIT = 4;
  localparam int PM_HI_BIT = 5;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  // program mode field codes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ATOMIC_TIME_NS = 3400000;
  localparam int SPLIT_TIME_NS = 1800000;
  localparam int ATOMIC_CYCLES = ATOMIC_TIME_NS / CLK_PERIOD_NS;
  localparam int SPLIT_CYCLES = SPLIT_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 20'h00001;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [CNT_W-1:0] READ_STALL = 3'h4;
  localparam logic [CNT_W-1:0] WRITE_STALL = 3'h2;
  localparam logic [CNT_W-1:0] MPE_WINDOW = 3'h4;
  // host wishbone map
  localparam int WB_ADDR_W = 4;
  localparam logic [WB_ADDR_W-1:0] WB_CTRL = 4'h0;
  localparam logic [WB_ADDR_W-1:0] WB_ADDR = 4'h4;
  localparam logic [WB_ADDR_W-1:0] WB_DATA = 4'h8;
  localparam logic [WB_ADDR_W-1:0] WB_STATUS = 4'hC;
  localparam int GO_BIT = 0;
  localparam int OPW_BIT = 1;
  localparam int GIE_BIT = 6;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_IRQ_BIT = 2;
  localparam int ST_SPM_BIT = 3;
endpackage

// ---- common/nvm_if.sv ----
/*
  cpu i/o register port between the cpu-side end and the device end.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface nvm_if;
  logic [nvm_pkg::REG_IDX_W-1:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [nvm_pkg::DATA_W-1:0] io_wdata;
  logic [nvm_pkg::DATA_W-1:0] io_rdata;
  logic io_stall;
  logic irq;
  logic gie;
  logic spm_busy;
  modport dev (
    input io_addr, io_wr, io_rd, io_wdata, gie, spm_busy,
    output io_rdata, io_stall, irq
  );
  modport cpu (
    output io_addr, io_wr, io_rd, io_wdata, gie, spm_busy,
    input io_rdata, io_stall, irq
  );
endinterface

// ---- hdl/nvm_device.sv ----
/*
  data store device end: address, data and control registers on the
  cpu i/o port, strobe interlock, self-timed programming, ready irq.
  assumes the cpu end waits while io_stall is high and issues at most
  one access per cycle.
*/
`timescale 1ns/1ns
module nvm_device #(
  parameter int ADDR_BITS = nvm_pkg::ADDR_W,
  parameter int ATOMIC_CYC = nvm_pkg::ATOMIC_CYCLES,
  parameter int SPLIT_CYC = nvm_pkg::SPLIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // cpu i/o port
  nvm_if.dev io,
  // status
  output logic busy_o
);
  import nvm_pkg::*;

  typedef struct packed {
    logic [1:0] mode;
    logic rie;
    logic mpe;
    logic pe;
    logic [CNT_W-1:0] mpe_cnt;
    logic [CNT_W-1:0] stall_cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] lat_addr;
    logic [DATA_W-1:0] lat_data;
    logic [1:0] lat_mode;
    logic [TIMER_W-1:0] timer;
    logic [DATA_W-1:0] rdata;
  } dev_state_type;

  localparam dev_state_type DEV_RESET = '0;

  dev_state_type s_q;
  dev_state_type s_d;
  dev_state_type held;

  logic [DATA_W-1:0] mem [0:(1<<ADDR_BITS)-1];
  logic [DATA_W-1:0] ctrl_view;
  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] mem_old;
  logic [DATA_W-1:0] prog_byte;
  logic [TIMER_W-1:0] op_cycles;
  logic [1:0] new_mode;
  logic wr_ctrl;
  logic start;
  logic rd_go;
  logic finish;

  // register views and program data
  always_comb begin
    ctrl_view = CTRL_RESET;
    ctrl_view[PM_HI_BIT] = s_q.mode[1];
    ctrl_view[PM_LO_BIT] = s_q.mode[0];
    ctrl_view[RIE_BIT] = s_q.rie;
    ctrl_view[MPE_BIT] = s_q.mpe;
    ctrl_view[PE_BIT] = s_q.pe;
    mem_rd = mem[s_q.addr[ADDR_BITS-1:0]];
    mem_old = mem[s_q.lat_addr[ADDR_BITS-1:0]];
    new_mode = {io.io_wdata[PM_HI_BIT], io.io_wdata[PM_LO_BIT]};
    if (new_mode == MODE_ATOMIC) begin
      op_cycles = TIMER_W'(ATOMIC_CYC);
    end else begin
      op_cycles = TIMER_W'(SPLIT_CYC);
    end
    case (s_q.lat_mode)
      MODE_ATOMIC: prog_byte = s_q.lat_data;
      MODE_ERASE: prog_byte = ERASED_BYTE;
      MODE_WRITE: prog_byte = mem_old & s_q.lat_data;
      default: prog_byte = mem_old;
    endcase
  end

  // access decode
  always_comb begin
    wr_ctrl = io.io_wr && (io.io_addr == REG_CTRL);
    start = wr_ctrl && io.io_wdata[PE_BIT] && s_q.mpe
      && !s_q.pe && !io.spm_busy
      && (new_mode != MODE_RSVD) && !rst_i;
    rd_go = wr_ctrl && io.io_wdata[READ_BIT] && !s_q.pe && !start
      && !rst_i;
    finish = s_q.pe && (s_q.timer == TIMER_ONE);
  end

  // next state
  always_comb begin
    s_d = s_q;
    held = s_q;
    if (s_q.mpe_cnt != '0) begin
      s_d.mpe_cnt = s_q.mpe_cnt - CNT_ONE;
      if (s_q.mpe_cnt == CNT_ONE) begin
        s_d.mpe = 1'b0;
      end
    end
    if (s_q.stall_cnt != '0) begin
      s_d.stall_cnt = s_q.stall_cnt - CNT_ONE;
    end
    if (s_q.pe && (s_q.timer != '0)) begin
      s_d.timer = s_q.timer - TIMER_ONE;
    end
    if (finish) begin
      s_d.pe = 1'b0;
    end
    if (io.io_wr) begin
      if (io.io_addr == REG_CTRL) begin
        if (!s_q.pe) begin
          s_d.mode = new_mode;
        end
        s_d.rie = io.io_wdata[RIE_BIT];
        if (io.io_wdata[MPE_BIT]) begin
          s_d.mpe = 1'b1;
          s_d.mpe_cnt = MPE_WINDOW;
        end
        if (start) begin
          s_d.pe = 1'b1;
          s_d.mpe = 1'b0;
          s_d.mpe_cnt = '0;
          s_d.lat_addr = s_q.addr;
          s_d.lat_data = s_q.data;
          s_d.lat_mode = new_mode;
          s_d.timer = op_cycles;
          s_d.stall_cnt = WRITE_STALL;
        end
        if (rd_go) begin
          s_d.data = mem_rd;
          s_d.stall_cnt = READ_STALL;
        end
      end else if (io.io_addr == REG_DATA) begin
        s_d.data = io.io_wdata;
      end else if (io.io_addr == REG_ADDR_LO) begin
        s_d.addr[7:0] = io.io_wdata;
      end else begin
        s_d.addr[ADDR_W-1:8] = io.io_wdata[ADDR_W-9:0];
      end
    end
    if (io.io_rd) begin
      if (io.io_addr == REG_CTRL) begin
        s_d.rdata = ctrl_view;
      end else if (io.io_addr == REG_DATA) begin
        s_d.rdata = s_q.data;
      end else if (io.io_addr == REG_ADDR_LO) begin
        s_d.rdata = s_q.addr[7:0];
      end else begin
        s_d.rdata = {{(16-ADDR_W){1'b0}}, s_q.addr[ADDR_W-1:8]};
      end
    end
    if (rst_i) begin
      held = s_d;
      s_d = DEV_RESET;
      s_d.pe = held.pe;
      s_d.timer = held.timer;
      s_d.lat_addr = held.lat_addr;
      s_d.lat_data = held.lat_data;
      s_d.lat_mode = held.lat_mode;
      if (held.pe) begin
        s_d.mode = held.mode;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // array update on completion, also under reset
  always_ff @(posedge clk_i) begin
    if (finish) begin
      mem[s_q.lat_addr[ADDR_BITS-1:0]] <= prog_byte;
    end
  end

  // outputs
  assign io.io_rdata = s_q.rdata;
  assign io.io_stall = (s_q.stall_cnt != '0);
  assign io.irq = !s_q.pe && s_q.rie && io.gie;
  assign busy_o = s_q.pe;
endmodule

// ---- hdl/nvm_host.sv ----
/*
  cpu-side end: takes byte read and write orders over classic wishbone
  and runs the i/o register sequences against the device end.
  assumes the device end answers io_rd one cycle later on io_rdata.
*/
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
module nvm_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // device i/o port
  nvm_if.cpu io,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [nvm_pkg::WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash self program busy
  input wire logic spm_busy_i
);
  import nvm_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_POLL, ST_CHECK, ST_ALO, ST_AHI, ST_DWR, ST_MPE,
    ST_STROBE, ST_RTRIG, ST_RDATA, ST_RCAP, ST_FINISH
  } host_state_type;

  typedef struct packed {
    host_state_type st;
    logic [REG_IDX_W-1:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [DATA_W-1:0] io_wdata;
    logic ack;
    logic [31:0] dat;
    logic op_write;
    logic [1:0] mode;
    logic rie;
    logic gie_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] result;
    logic done;
  } host_reg_type;

  localparam host_reg_type HOST_RESET = '0;

  host_reg_type s_q;
  host_reg_type s_d;
  logic free;
  logic take;
  logic busy;
  logic [31:0] status;

  function automatic logic [DATA_W-1:0] ctrl_byte(
    input logic [1:0] m,
    input logic r,
    input logic mp,
    input logic p,
    input logic rd
  );
    logic [DATA_W-1:0] b;
    b = CTRL_RESET;
    b[PM_HI_BIT] = m[1];
    b[PM_LO_BIT] = m[0];
    b[RIE_BIT] = r;
    b[MPE_BIT] = mp;
    b[PE_BIT] = p;
    b[READ_BIT] = rd;
    return b;
  endfunction

  always_comb begin
    busy = (s_q.st != ST_IDLE);
    free = !s_q.io_wr && !s_q.io_rd && !io.io_stall;
    take = wb_cyc_i && wb_stb_i && !s_q.ack;
    status = 32'h0000_0000;
    status[ST_BUSY_BIT] = busy;
    status[ST_DONE_BIT] = s_q.done;
    status[ST_IRQ_BIT] = io.irq;
    status[ST_SPM_BIT] = spm_busy_i;
  end

  always_comb begin
    s_d = s_q;
    s_d.io_wr = 1'b0;
    s_d.io_rd = 1'b0;
    s_d.ack = take;
    // sequencer
    case (s_q.st)
      ST_POLL: begin
        if (free) begin
          s_d.io_addr = REG_CTRL;
          s_d.io_rd = 1'b1;
          s_d.st = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // wait one cycle: read data stands only after the read is taken
        if (!s_q.io_rd) begin
          if (io.io_rdata[PE_BIT] || spm_busy_i) begin
            s_d.st = ST_POLL;
          end else begin
            s_d.st = ST_ALO;
          end
        end
      end
      ST_ALO: begin
        if (free) begin
          s_d.io_addr = REG_ADDR_LO;
          s_d.io_wdata = s_q.addr[7:0];
          s_d.io_wr = 1'b1;
          s_d.st = ST_AHI;
        end
      end
      ST_AHI: begin
        if (free) begin
          s_d.io_addr = REG_ADDR_HI;
          s_d.io_wdata = {{(16-ADDR_W){1'b0}}, s_q.addr[ADDR_W-1:8]};
          s_d.io_wr = 1'b1;
          s_d.st = s_q.op_write ? ST_DWR : ST_RTRIG;
        end
      end
      ST_DWR: begin
        if (free) begin
          s_d.io_addr = REG_DATA;
          s_d.io_wdata = s_q.data;
          s_d.io_wr = 1'b1;
          s_d.st = ST_MPE;
        end
      end
      ST_MPE: begin
        if (free) begin
          s_d.io_addr = REG_CTRL;
          s_d.io_wdata = ctrl_byte(s_q.mode, s_q.rie, 1'b1, 1'b0,
            1'b0);
          s_d.io_wr = 1'b1;
          s_d.st = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (free) begin
          s_d.io_wdata = ctrl_byte(s_q.mode, s_q.rie, 1'b1, 1'b1,
            1'b0);
          s_d.io_wr = 1'b1;
          s_d.st = ST_FINISH;
        end
      end
      ST_RTRIG: begin
        if (free) begin
          s_d.io_addr = REG_CTRL;
          s_d.io_wdata = ctrl_byte(s_q.mode, s_q.rie, 1'b0, 1'b0,
            1'b1);
          s_d.io_wr = 1'b1;
          s_d.st = ST_RDATA;
        end
      end
      ST_RDATA: begin
        if (free) begin
          s_d.io_addr = REG_DATA;
          s_d.io_rd = 1'b1;
          s_d.st = ST_RCAP;
        end
      end
      ST_RCAP: begin
        if (!s_q.io_rd) begin
          s_d.result = io.io_rdata;
          s_d.st = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (free) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // wishbone register access
    s_d.dat = 32'h0000_0000;
    if (take && wb_we_i) begin
      if (wb_adr_i == WB_CTRL) begin
        if (wb_sel_i[0] && !busy) begin
          s_d.op_write = wb_dat_i[OPW_BIT];
          s_d.mode = {wb_dat_i[PM_HI_BIT], wb_dat_i[PM_LO_BIT]};
          s_d.rie = wb_dat_i[RIE_BIT];
          s_d.gie_en = wb_dat_i[GIE_BIT];
          if (wb_dat_i[GO_BIT]) begin
            s_d.done = 1'b0;
            s_d.st = ST_POLL;
          end
        end
      end else if (wb_adr_i == WB_ADDR) begin
        if (wb_sel_i[0] && !busy) begin
          s_d.addr[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1] && !busy) begin
          s_d.addr[ADDR_W-1:8] = wb_dat_i[ADDR_W-1:8];
        end
      end else if (wb_adr_i == WB_DATA) begin
        if (wb_sel_i[0] && !busy) begin
          s_d.data = wb_dat_i[7:0];
        end
      end else if (wb_adr_i == WB_STATUS) begin
        if (wb_sel_i[0] && wb_dat_i[ST_DONE_BIT]) begin
          s_d.done = 1'b0;
        end
      end
    end else if (take) begin
      if (wb_adr_i == WB_CTRL) begin
        s_d.dat[OPW_BIT] = s_q.op_write;
        s_d.dat[PM_HI_BIT] = s_q.mode[1];
        s_d.dat[PM_LO_BIT] = s_q.mode[0];
        s_d.dat[RIE_BIT] = s_q.rie;
        s_d.dat[GIE_BIT] = s_q.gie_en;
      end else if (wb_adr_i == WB_ADDR) begin
        s_d.dat[ADDR_W-1:0] = s_q.addr;
      end else if (wb_adr_i == WB_DATA) begin
        s_d.dat[7:0] = s_q.result;
      end else if (wb_adr_i == WB_STATUS) begin
        s_d.dat = status;
      end
    end
    // completion sets done, winning over a clear
    if ((s_q.st == ST_FINISH) && free) begin
      s_d.done = 1'b1;
    end
    if (rst_i) begin
      s_d = HOST_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign io.io_addr = s_q.io_addr;
  assign io.io_wr = s_q.io_wr;
  assign io.io_rd = s_q.io_rd;
  assign io.io_wdata = s_q.io_wdata;
  assign io.gie = s_q.gie_en && !busy;
  assign io.spm_busy = spm_busy_i;
  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
endmodule

// ---- tb/nvm_assertions.sv ----
/*
  assertions on the i/o port joining the cpu end and the device end.
  assumes one clock, synchronous high reset, short programming counts.
*/
`timescale 1ns/1ns
module nvm_assertions
  import nvm_pkg::*;
#(
  parameter int ATOMIC_CYC = 20,
  parameter int SPLIT_CYC = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // i/o port
  input wire logic [REG_IDX_W-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [DATA_W-1:0] io_wdata,
  input wire logic [DATA_W-1:0] io_rdata,
  input wire logic io_stall,
  input wire logic irq,
  input wire logic gie,
  input wire logic spm_busy,
  // device status
  input wire logic busy_o
);
  logic ctl_wr;
  logic [2:0] win_q;
  logic [2:0] stl_q;
  logic [TIMER_W-1:0] bsy_q;
  assign ctl_wr = io_wr && io_addr == REG_CTRL;
  // enable window, stall length, busy length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q <= 3'h0;
    end else if (ctl_wr && io_wdata[MPE_BIT] && !io_wdata[PE_BIT]) begin
      win_q <= 3'h4;
    end else if (win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end
    stl_q <= io_stall ? stl_q + 3'h1 : 3'h0;
    bsy_q <= busy_o ? bsy_q + TIMER_ONE : '0;
  end
  default clocking dflt @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rd_stall;
    ctl_wr && io_wdata[READ_BIT] && !busy_o |=> io_stall [*4] ##1 !io_stall;
  endproperty
  a_rd_stall: assert property (p_rd_stall)
    else $error("read stall wrong");
  property p_start;
    ctl_wr && io_wdata[PE_BIT] && win_q != 3'h0 && !busy_o && !spm_busy
      && io_wdata[PM_HI_BIT:PM_LO_BIT] != MODE_RSVD
      |=> busy_o && io_stall ##1 io_stall ##1 !io_stall;
  endproperty
  a_start: assert property (p_start)
    else $error("start refused or bad stall");
  property p_no_mpe;
    ctl_wr && io_wdata[PE_BIT] && win_q == 3'h0 && !busy_o |=> !busy_o;
  endproperty
  a_no_mpe: assert property (p_no_mpe)
    else $error("start without enable");
  property p_spm;
    ctl_wr && io_wdata[PE_BIT] && spm_busy && !busy_o |=> !busy_o;
  endproperty
  a_spm: assert property (p_spm)
    else $error("start while flash busy");
  property p_stall_len;
    $fell(io_stall) |-> stl_q == 3'h2 || stl_q == 3'h4;
  endproperty
  a_stall_len: assert property (p_stall_len)
    else $error("stall length wrong");
  property p_busy_len;
    $fell(busy_o) |-> bsy_q == ATOMIC_CYC || bsy_q == SPLIT_CYC;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("program time wrong");
  property p_irq_busy;
    busy_o |-> !irq;
  endproperty
  a_irq_busy: assert property (p_irq_busy)
    else $error("irq while programming");
  property p_irq_gie;
    !gie |-> !irq;
  endproperty
  a_irq_gie: assert property (p_irq_gie)
    else $error("irq without gie");
  property p_rd_hold;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
endmodule

// ---- tb/eeprom_data_access_control_test.sv ----
/*
  self-checking bench: host and device ends joined by the i/o interface,
  driven over wishbone and compared with a byte model.
  assumes short programming counts and no other bus master.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); \
  end \
end
module eeprom_data_access_control_test;
  import nvm_pkg::*;
  localparam int AC = 20;
  localparam int SC = 10;
  logic clk_i;
  logic rst_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [3:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic spm_busy_i;
  logic busy_o;
  logic [31:0] rd_q;
  int seed;
  int n_mismatch;
  int num_checks;
  int cfg;
  int a;
  int mem [int];
  nvm_if nvm_if_inst ();
  nvm_device #(.ATOMIC_CYC(AC), .SPLIT_CYC(SC)) nvm_device_inst (
    .clk_i(clk_i), .rst_i(rst_i), .io(nvm_if_inst), .busy_o(busy_o));
  nvm_host nvm_host_inst (.clk_i(clk_i), .rst_i(rst_i), .io(nvm_if_inst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spm_busy_i(spm_busy_i));
  nvm_assertions #(.ATOMIC_CYC(AC), .SPLIT_CYC(SC)) nvm_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .io_addr(nvm_if_inst.io_addr),
    .io_wr(nvm_if_inst.io_wr), .io_rd(nvm_if_inst.io_rd),
    .io_wdata(nvm_if_inst.io_wdata), .io_rdata(nvm_if_inst.io_rdata),
    .io_stall(nvm_if_inst.io_stall), .irq(nvm_if_inst.irq),
    .gie(nvm_if_inst.gie), .spm_busy(nvm_if_inst.spm_busy),
    .busy_o(busy_o));
  always #2 clk_i = ~clk_i;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic give_up();
    n_mismatch++;
    end_of_test();
  endtask
  // one classic wishbone cycle
  task automatic wb(input logic we, input logic [3:0] adr,
      input logic [31:0] dat);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (i == 20) give_up();
  endtask
  task automatic poll(input int b, input logic v);
    int i;
    for (i = 0; i < 300; i++) begin
      wb(1'b0, WB_STATUS, 32'h0);
      if (rd_q[b] === v) break;
    end
    if (i == 300) give_up();
  endtask
  // start a program order and update the model
  task automatic go_wr(input int adr, input logic [1:0] m,
      input logic [7:0] d);
    wb(1'b1, WB_ADDR, 32'(adr));
    wb(1'b1, WB_DATA, {24'h0, d});
    wb(1'b1, WB_CTRL, 32'(cfg) | {26'h0, m, 4'h3});
    case (m)
      MODE_ATOMIC: mem[adr] = d;
      MODE_ERASE: mem[adr] = ERASED_BYTE;
      MODE_WRITE: mem[adr] = mem[adr] & d;
      default: ;
    endcase
  endtask
  task automatic chk_rd(input int adr);
    wb(1'b1, WB_ADDR, 32'(adr));
    wb(1'b1, WB_CTRL, 32'(cfg) | 32'h1);
    poll(ST_DONE_BIT, 1'b1);
    poll(ST_BUSY_BIT, 1'b0);
    wb(1'b0, WB_DATA, 32'h0);
    `CHK("byte", 8'(mem[adr]), rd_q[7:0])
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    spm_busy_i = 1'b0;
    seed = 72584;
    n_mismatch = 0;
    num_checks = 0;
    cfg = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, WB_STATUS, 32'h0);
    `CHK("status", 32'h0, rd_q)
    wb(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, rd_q)
    $display("scenario reset state done");
    // every mode code on random places
    for (int k = 0; k < 3; k++) begin
      a = $random(seed) & 32'h7FF;
      for (int m = 0; m < 4; m++) begin
        go_wr(a, 2'(m), 8'($random(seed)));
        poll(ST_DONE_BIT, 1'b1);
        poll(ST_BUSY_BIT, 1'b0);
        chk_rd(a);
      end
    end
    $display("scenario modes done");
    cfg = 32'h48;
    chk_rd(a);
    wb(1'b0, WB_STATUS, 32'h0);
    `CHK("irq on", 1'b1, rd_q[ST_IRQ_BIT])
    cfg = 0;
    chk_rd(a);
    wb(1'b0, WB_STATUS, 32'h0);
    `CHK("irq off", 1'b0, rd_q[ST_IRQ_BIT])
    $display("scenario irq done");
    // flash self program lock
    spm_busy_i <= 1'b1;
    go_wr(a, MODE_ATOMIC, 8'($random(seed)));
    repeat (4) wb(1'b0, WB_STATUS, 32'h0);
    `CHK("spm flag", 1'b1, rd_q[ST_SPM_BIT])
    `CHK("spm hold", 1'b0, busy_o)
    spm_busy_i <= 1'b0;
    poll(ST_DONE_BIT, 1'b1);
    poll(ST_BUSY_BIT, 1'b0);
    chk_rd(a);
    $display("scenario flash lock done");
    // flash busy rising inside the order: strobe refused, byte kept
    wb(1'b1, WB_ADDR, 32'(a));
    wb(1'b1, WB_DATA, 32'h0);
    wb(1'b1, WB_CTRL, 32'h3);
    repeat (6) @(posedge clk_i);
    spm_busy_i <= 1'b1;
    poll(ST_DONE_BIT, 1'b1);
    `CHK("spm refuse", 1'b0, busy_o)
    spm_busy_i <= 1'b0;
    poll(ST_BUSY_BIT, 1'b0);
    chk_rd(a);
    $display("scenario flash late lock done");
    // reset in mid programming
    go_wr(a, MODE_ATOMIC, 8'($random(seed)));
    poll(ST_DONE_BIT, 1'b1);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("busy in reset", 1'b1, busy_o)
    rst_i <= 1'b0;
    @(posedge clk_i);
    poll(ST_BUSY_BIT, 1'b0);
    chk_rd(a);
    $display("scenario reset in program done");
    end_of_test();
  end
endmodule
